// ===== ird_defines.svh
// Timing and width constants for the reset distribution block.
`ifndef IRD_DEFINES_SVH
`define IRD_DEFINES_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define IRD_CLK_PERIOD_PS   4000
`define IRD_STRETCH_NS      40
`define IRD_STRETCH_CYC     ((`IRD_STRETCH_NS * 1000 + `IRD_CLK_PERIOD_PS - 1) / `IRD_CLK_PERIOD_PS)
`define IRD_CNT_W           4
`define IRD_CNT_ZERO        4'h0

`endif

// ===== ird_host_model.sv
// Host platform model driving the reset pins and the supply strap.
`timescale 1ns/1ps
module ird_host_model (
    // Clock and requests, active high
    input  wire logic       clk_sys,
    input  wire logic [2:0] hold_reset,
    input  wire logic       aux_supply,
    // Pins towards the device
    output logic            alternate_reset_n,
    output logic            pci_reset_n,
    output logic            isolation_input_n,
    output logic            flash_addr1_aux_power_strap
);
    // Pins start idle.
    initial begin
        {alternate_reset_n, pci_reset_n, isolation_input_n} = 3'h7;
        flash_addr1_aux_power_strap = 1'b0;
    end
    // Strap shows the supply pull only in PCI reset; otherwise the address output toggles.
    always @(posedge clk_sys) begin
        #1;
        {alternate_reset_n, pci_reset_n, isolation_input_n} <= ~hold_reset;
        flash_addr1_aux_power_strap <= hold_reset[1] ? aux_supply : ~flash_addr1_aux_power_strap;
    end
endmodule : ird_host_model

// ===== ird_pkg.sv
// Types shared by the reset distribution block.
package ird_pkg;

    // ----------------------------------------------------------------
    // Unit reset strobes, one bit per unit, active high
    // ----------------------------------------------------------------
    typedef struct packed {
        logic eeprom_load;
        logic microcode;
        logic mac_config;
        logic mem_pointers;
        logic pci_config;
        logic phy_config;
        logic pm_event;
        logic stat_counters;
    } ird_unit_resets_t;

    // ----------------------------------------------------------------
    // Configuration gate state
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        IRD_CFG_HOLD  = 2'b00,
        IRD_CFG_LOAD  = 2'b01,
        IRD_CFG_READY = 2'b10
    } ird_cfg_state_t;

endpackage : ird_pkg

// ===== ird_reset_dist.sv
// Reset source combining and per-unit reset distribution.
//
// Function
// - Four ranked sources: alternate pin, PCI, software, selective.
// - Software-cleared state also cleared by stronger sources.
// - Pin resets all, PCI all but PM events on aux power; PHY only them.
// - EEPROM load restarts on pin, PCI, isolation only.
// - MAC config and hash: pin, PCI, isolation, D3-D0.
// - Memory pointers reset by all except isolation.
// - PCI config: pin, PCI, isolation, D3-D0.
// - PM events: pin always, PCI without auxiliary power.
// - Retry configuration accesses until EEPROM load done.
//
// Every unit strobe is a registered, active-high level. A strobe rises one
// cycle after an internal request and three cycles after a pin falls, since
// the pins first pass a two-stage synchroniser. Each strobe then stays high
// for STRETCH_CYC cycles beyond the last cycle its source was seen, so that
// a one-cycle request still reaches units that sample it slowly.
// Limitation: reset_n holds every strobe high only while it is low; the
// strobes drop at the first edge after its release unless an internal request is active.
`timescale 1ns/1ps
`include "ird_defines.svh"

module ird_reset_dist #(
    parameter int STRETCH_CYC = `IRD_STRETCH_CYC
) (
    // Clock and reset
    input  wire logic                      clk_sys,
    input  wire logic                      reset_n,
    // Asynchronous reset pins and supply strap
    input  wire logic                      alternate_reset_n,
    input  wire logic                      pci_reset_n,
    input  wire logic                      isolation_input_n,
    input  wire logic                      flash_addr1_aux_power_strap,
    // Internal requests, same clock, one-cycle pulses
    input  wire logic                      d3_to_d0,
    input  wire logic                      software_reset,
    input  wire logic                      selective_reset,
    // EEPROM loader handshake
    input  wire logic                      eeprom_load_done,
    // Unit resets and status
    output ird_pkg::ird_unit_resets_t      unit_resets,
    output logic                           aux_power,
    output logic                           config_retry
);

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    logic [3:0] sync_a;
    logic [3:0] sync_b;
    logic [3:0] raw_in;
    // Raw pin vector: strap, isolation, PCI reset, alternate reset.
    assign raw_in = {flash_addr1_aux_power_strap, isolation_input_n, pci_reset_n, alternate_reset_n};

    // Both stages reset to ones, the idle level of the active-low pins, so the
    // release of reset_n can never be mistaken for a pin reset.
    // Two flops per pin; only the second stage is read by logic.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sync_a <= 4'hF;
            sync_b <= 4'hF;
        end else begin
            sync_a <= raw_in;
            sync_b <= sync_a;
        end
    end

    // Active-high views of the synchronised pins; the strap keeps its polarity.
    logic alt_act;
    logic pci_act;
    logic iso_act;
    logic strap_s;
    assign alt_act = ~sync_b[0];
    assign pci_act = ~sync_b[1];
    assign iso_act = ~sync_b[2];
    assign strap_s = sync_b[3];

    // ----------------------------------------------------------------
    // Auxiliary power strap capture
    // ----------------------------------------------------------------
    logic next_aux_power;

    // The strap is valid only while PCI reset is active, so track it then.
    // Outside PCI reset the pin carries a flash address and is ignored.
    always_comb begin
        next_aux_power = aux_power;
        if (pci_act) begin
            next_aux_power = strap_s;
        end
    end

    // Registers the supply indication.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            aux_power <= 1'b0;
        end else begin
            aux_power <= next_aux_power;
        end
    end

    // ----------------------------------------------------------------
    // Source to unit mapping
    // ----------------------------------------------------------------
    logic hw_rst;
    logic soft_rst;
    ird_pkg::ird_unit_resets_t raw_map;

    // Hardware sources outrank the rest; each unit takes the union of its sources.
    // The event strobe uses this cycle's strap value, so a PCI reset on an
    // auxiliary supply never clears it, not even in its first cycle.
    always_comb begin
        hw_rst                 = alt_act | pci_act;
        soft_rst               = hw_rst | d3_to_d0 | software_reset;
        raw_map.eeprom_load    = hw_rst | iso_act;
        raw_map.microcode      = soft_rst;
        raw_map.mac_config     = hw_rst | iso_act | d3_to_d0;
        raw_map.mem_pointers   = soft_rst | selective_reset;
        raw_map.pci_config     = hw_rst | iso_act | d3_to_d0;
        raw_map.phy_config     = hw_rst;
        raw_map.pm_event       = alt_act | (pci_act & ~next_aux_power);
        raw_map.stat_counters  = soft_rst;
    end

    // ----------------------------------------------------------------
    // Pulse stretchers, one per unit
    // ----------------------------------------------------------------
    localparam int NUNITS = $bits(ird_pkg::ird_unit_resets_t);
    localparam logic [`IRD_CNT_W-1:0] STRETCH_LOAD = `IRD_CNT_W'(STRETCH_CYC);
    logic [NUNITS-1:0] map_vec;
    wire logic [NUNITS-1:0] out_vec;
    // Flattens the source map so that one loop serves every unit.
    assign map_vec = raw_map;

    genvar gi;
    generate
        for (gi = 0; gi < NUNITS; gi++) begin : g_stretch
            logic [`IRD_CNT_W-1:0] cnt;
            logic [`IRD_CNT_W-1:0] next_cnt;
            logic                  next_out;
            logic                  out_q;

            // Short requests are held long enough for every unit to see them.
            always_comb begin
                next_cnt = cnt;
                if (map_vec[gi]) begin
                    next_cnt = STRETCH_LOAD;
                end else if (cnt != `IRD_CNT_ZERO) begin
                    next_cnt = cnt - `IRD_CNT_W'(1);
                end
                next_out = map_vec[gi] | (cnt != `IRD_CNT_ZERO);
            end

            // Registers the counter and the strobe; the strobe is high in reset.
            always_ff @(posedge clk_sys or negedge reset_n) begin
                if (!reset_n) begin
                    cnt   <= `IRD_CNT_ZERO;
                    out_q <= 1'b1;
                end else begin
                    cnt   <= next_cnt;
                    out_q <= next_out;
                end
            end

            // Each stage drives only its own bit of the strobe vector.
            assign out_vec[gi] = out_q;
        end
    endgenerate

    // The strobe vector goes out in the field order of the unit struct.
    assign unit_resets = out_vec;

    // ----------------------------------------------------------------
    // Configuration retry gate
    // ----------------------------------------------------------------
    ird_pkg::ird_cfg_state_t cfg_state;
    ird_pkg::ird_cfg_state_t next_cfg_state;
    logic                    next_retry;

    // Retry from reset until the loader reports the EEPROM read complete.
    // A done report is ignored while a load source is still active, and any
    // new load source sends the gate back to HOLD whatever the loader says.
    always_comb begin
        next_cfg_state = cfg_state;
        unique case (cfg_state)
            ird_pkg::IRD_CFG_HOLD: begin
                if (!raw_map.eeprom_load) begin
                    next_cfg_state = ird_pkg::IRD_CFG_LOAD;
                end
            end
            ird_pkg::IRD_CFG_LOAD: begin
                if (raw_map.eeprom_load) begin
                    next_cfg_state = ird_pkg::IRD_CFG_HOLD;
                end else if (eeprom_load_done) begin
                    next_cfg_state = ird_pkg::IRD_CFG_READY;
                end
            end
            ird_pkg::IRD_CFG_READY: begin
                if (raw_map.eeprom_load) begin
                    next_cfg_state = ird_pkg::IRD_CFG_HOLD;
                end
            end
            default: begin
                next_cfg_state = ird_pkg::IRD_CFG_HOLD;
            end
        endcase
        next_retry = (next_cfg_state != ird_pkg::IRD_CFG_READY);
    end

    // Registers the gate state and the retry flag.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cfg_state    <= ird_pkg::IRD_CFG_HOLD;
            config_retry <= 1'b1;
        end else begin
            cfg_state    <= next_cfg_state;
            config_retry <= next_retry;
        end
    end

endmodule : ird_reset_dist

// ===== ird_reset_dist_sva.sv
// Assertion checker for the reset distribution block.
`timescale 1ns/1ps
module ird_reset_dist_sva #(
    parameter int STRETCH_CYC = 10
) (
    // Clock and reset
    input wire logic                      clk_sys,
    input wire logic                      reset_n,
    // Pins and requests
    input wire logic                      alternate_reset_n,
    input wire logic                      pci_reset_n,
    input wire logic                      isolation_input_n,
    input wire logic                      flash_addr1_aux_power_strap,
    input wire logic                      d3_to_d0,
    input wire logic                      software_reset,
    input wire logic                      selective_reset,
    input wire logic                      eeprom_load_done,
    // Outputs
    input wire ird_pkg::ird_unit_resets_t unit_resets,
    input wire logic                      aux_power,
    input wire logic                      config_retry
);
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);
    // Each property ties a unit strobe or the retry flag to the source that must drive it.
    sw_units_a: assert property (software_reset |=> (unit_resets & 8'h51) == 8'h51)
        else $error("software reset missed a unit");
    d3_units_a: assert property (d3_to_d0 |=> (unit_resets & 8'h79) == 8'h79)
        else $error("power transition missed a unit");
    sel_units_a: assert property (selective_reset |=> unit_resets.mem_pointers)
        else $error("selective reset missed pointers");
    alt_all_a: assert property ($fell(alternate_reset_n) ##1 !alternate_reset_n [*2] |=> unit_resets == 8'hFF)
        else $error("alternate pin missed a unit");
    iso_units_a: assert property (!isolation_input_n [*3] |=> (unit_resets & 8'hA8) == 8'hA8)
        else $error("isolation missed a unit");
    phy_hw_a: assert property ($rose(unit_resets.phy_config) |-> $past(!alternate_reset_n || !pci_reset_n, 3))
        else $error("phy reset without a hardware source");
    pm_hw_a: assert property ($rose(unit_resets.pm_event) |-> $past(!alternate_reset_n || !pci_reset_n, 3))
        else $error("event reset without a hardware source");
    retry_done_a: assert property ($fell(config_retry) |-> $past(eeprom_load_done))
        else $error("retry ended before load done");
    retry_load_a: assert property ($rose(unit_resets.eeprom_load) |-> ##[0:2] config_retry)
        else $error("load restarted without retry");
    // Main scenarios seen.
    cover property (software_reset);
    cover property ($fell(alternate_reset_n));
    cover property ($fell(config_retry));
endmodule : ird_reset_dist_sva

// ===== ird_reset_dist_tb.sv
// Self-checking testbench for the reset distribution block.
`timescale 1ns/1ps
`define CHK(a, b, m) begin checks++; if ((a) !== (b)) begin num_errors++; $display("Error %0t: %s", $time, m); end end
module ird_reset_dist_tb;
    localparam int S = 2;
    logic clk_sys, reset_n, d3_to_d0, software_reset, selective_reset, eeprom_load_done, aux_supply;
    logic alternate_reset_n, pci_reset_n, isolation_input_n, flash_addr1_aux_power_strap, aux_power, config_retry;
    logic [2:0] hold_reset;
    ird_pkg::ird_unit_resets_t unit_resets;
    int num_errors = 0;
    int checks = 0;
    // Device and platform.
    ird_reset_dist #(.STRETCH_CYC(S)) u_dut (.clk_sys, .reset_n, .alternate_reset_n, .pci_reset_n,
        .isolation_input_n, .flash_addr1_aux_power_strap, .d3_to_d0, .software_reset, .selective_reset,
        .eeprom_load_done, .unit_resets, .aux_power, .config_retry);
    ird_host_model u_host (.clk_sys, .hold_reset, .aux_supply, .alternate_reset_n, .pci_reset_n,
        .isolation_input_n, .flash_addr1_aux_power_strap);
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : cyc
    // Ends the load and checks that retry stops.
    task automatic load_done();
        eeprom_load_done = 1'b1;
        cyc(1);
        eeprom_load_done = 1'b0;
        `CHK(config_retry, 1'b0, "retry on after load")
    endtask : load_done
    // Units held in reset and freed at the first edge after it; configuration retried until load ends.
    task automatic t_init();
        `CHK(unit_resets, 8'hFF, "units free in reset")
        `CHK(config_retry, 1'b1, "retry off in reset")
        reset_n = 1'b1;
        cyc(1);
        `CHK(unit_resets, 8'h00, "units still held")
        `CHK(config_retry, 1'b1, "retry off early")
        load_done();
    endtask : t_init
    // Internal pulses, alone and together, reach their units for the stretch.
    task automatic t_pulse(input logic [2:0] req, input ird_pkg::ird_unit_resets_t exp);
        {d3_to_d0, software_reset, selective_reset} = req;
        cyc(1);
        {d3_to_d0, software_reset, selective_reset} = 3'h0;
        `CHK(unit_resets, exp, "pulse units wrong")
        cyc(S);
        `CHK(unit_resets, exp, "stretch short")
        cyc(1);
        `CHK(unit_resets, 8'h00, "stretch long")
        `CHK(config_retry, 1'b0, "load restarted")
    endtask : t_pulse
    // Pin resets reach their units and restart the load.
    task automatic t_pin(input logic [2:0] pins, input logic aux, input ird_pkg::ird_unit_resets_t exp);
        aux_supply = aux;
        hold_reset = pins;
        cyc(5);
        `CHK(unit_resets, exp, "pin units wrong")
        hold_reset = 3'h0;
        cyc(S + 6);
        `CHK(unit_resets, 8'h00, "pin units held")
        `CHK(config_retry, 1'b1, "load not restarted")
        if (pins[1]) `CHK(aux_power, aux, "supply strap lost")
        load_done();
    endtask : t_pin
    task automatic end_of_test();
        if (num_errors == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test
    // Clock.
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    // Watchdog.
    initial begin
        #8000;
        num_errors++;
        end_of_test();
    end
    // Main sequence.
    initial begin
        {reset_n, d3_to_d0, software_reset, selective_reset, eeprom_load_done, aux_supply} = 6'h00;
        hold_reset = 3'h0;
        cyc(10);
        t_init();
        t_pulse(3'h2, 8'h51);
        t_pulse(3'h4, 8'h79);
        t_pulse(3'h1, 8'h10);
        t_pulse(3'h3, 8'h51);
        t_pulse(3'h7, 8'h79);
        t_pin(3'h4, 1'b1, 8'hFF);
        t_pin(3'h2, 1'b0, 8'hFF);
        t_pin(3'h2, 1'b1, 8'hFD);
        t_pin(3'h1, 1'b0, 8'hA8);
        end_of_test();
    end
endmodule : ird_reset_dist_tb
bind ird_reset_dist ird_reset_dist_sva #(.STRETCH_CYC(STRETCH_CYC)) u_sva (.clk_sys, .reset_n, .alternate_reset_n,
    .pci_reset_n, .isolation_input_n, .flash_addr1_aux_power_strap, .d3_to_d0, .software_reset, .selective_reset,
    .eeprom_load_done, .unit_resets, .aux_power, .config_retry);
